// ---- hw/seeprm_host.sv ----
// Master end of the two-wire link: makes the serial clock, START/STOP
// and control bytes. Assumes a single memory end and no clock stretching.
`timescale 1ns/1ps
module seeprm_host #(
  parameter int SCL_QTR = seeprm_pkg::SEE_SCL_QTR
) (
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_I,
  seeprm_if.host                      LINK,
  input  wire logic                   CMD_VALID_I,
  output logic                        CMD_READY_O,
  input  wire seeprm_pkg::seeprm_cmd_t CMD_KIND_I,
  input  wire logic [10:0]            CMD_ADDR_I,
  input  wire logic [7:0]             CMD_DATA_I,
  input  wire logic [7:0]             CMD_LEN_I,
  output logic [7:0]                  RD_DATA_O,
  output logic                        RD_VALID_O,
  output logic                        DONE_O,
  output logic                        NACK_O
);
  import seeprm_pkg::*;

  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic        sda_f_r;
  seeprm_hst_t state_r;
  seeprm_cmd_t kind_r;
  logic [10:0] addr_r;
  logic [7:0]  data_r;
  logic [7:0]  left_r;
  logic [15:0] qcnt_r;
  logic [1:0]  ph_r;
  logic [3:0]  bcnt_r;
  logic [7:0]  txb_r;
  logic [7:0]  rxb_r;
  logic        ack_r;
  logic        nack_r;
  logic        scl_r;
  logic        oe_r;
  logic        want_scl;
  logic        want_oe;
  logic        tick;
  logic        tx_op;

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      sda_f_r <= 1'b1;
    end
    else
    begin
      s1_r    <= LINK.sda;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      sda_f_r <= (s2_r == s3_r) ? s3_r : sda_f_r;
    end
  end

  assign tx_op = (state_r == H_CTRLW) || (state_r == H_ADDR) ||
                 (state_r == H_DATA) || (state_r == H_CTRLR);
  assign tick  = (state_r != H_IDLE) && (qcnt_r == 16'(SCL_QTR - 1));

  // Data only moves while the clock is low; START/STOP move it high.
  always_comb
  begin
    want_scl = 1'b1;
    want_oe  = 1'b0;
    unique case (state_r)
      H_IDLE:
      begin
        want_scl = 1'b1;
        want_oe  = 1'b0;
      end
      H_START, H_RESTART:
      begin
        want_scl = (ph_r == 2'h1) || (ph_r == 2'h2);
        want_oe  = ph_r[1];
      end
      H_STOP:
      begin
        want_scl = (ph_r != 2'h0);
        want_oe  = !ph_r[1];
      end
      H_READ:
      begin
        want_scl = (ph_r == 2'h1) || (ph_r == 2'h2);
        want_oe  = (bcnt_r == 4'h8) && (left_r != 8'h01);
      end
      default:
      begin
        want_scl = (ph_r == 2'h1) || (ph_r == 2'h2);
        want_oe  = (bcnt_r != 4'h8) && !txb_r[7];
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      scl_r <= 1'b1;
      oe_r  <= 1'b0;
    end
    else
    begin
      scl_r <= want_scl;
      oe_r  <= want_oe;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_r    <= H_IDLE;
      kind_r     <= SEE_CMD_WRITE;
      addr_r     <= 11'h000;
      data_r     <= 8'h00;
      left_r     <= 8'h00;
      qcnt_r     <= 16'h0000;
      ph_r       <= 2'h0;
      bcnt_r     <= 4'h0;
      txb_r      <= 8'h00;
      rxb_r      <= 8'h00;
      ack_r      <= 1'b0;
      nack_r     <= 1'b0;
      RD_DATA_O  <= 8'h00;
      RD_VALID_O <= 1'b0;
      DONE_O     <= 1'b0;
      NACK_O     <= 1'b0;
    end
    else
    begin
      RD_VALID_O <= 1'b0;
      DONE_O     <= 1'b0;
      if (state_r == H_IDLE)
      begin
        if (CMD_VALID_I)
        begin
          state_r <= H_START;
          kind_r  <= CMD_KIND_I;
          addr_r  <= CMD_ADDR_I;
          data_r  <= CMD_DATA_I;
          left_r  <= (CMD_LEN_I == 8'h00) ? 8'h01 : CMD_LEN_I;
          qcnt_r  <= 16'h0000;
          ph_r    <= 2'h0;
          bcnt_r  <= 4'h0;
          nack_r  <= 1'b0;
        end
      end
      else if (!tick)
        qcnt_r <= qcnt_r + 16'h0001;
      else
      begin
        qcnt_r <= 16'h0000;
        ph_r   <= ph_r + 2'h1;
        if (ph_r == 2'h1)
        begin
          if (tx_op && bcnt_r == 4'h8)
            ack_r <= !sda_f_r;
          if (state_r == H_READ && bcnt_r != 4'h8)
            rxb_r <= {rxb_r[6:0], sda_f_r};
        end
        if (ph_r == 2'h3)
        begin
          if ((tx_op || state_r == H_READ) && bcnt_r != 4'h8)
          begin
            bcnt_r <= bcnt_r + 4'h1;
            txb_r  <= {txb_r[6:0], 1'b0};
          end
          else
          begin
            bcnt_r <= 4'h0;
            unique case (state_r)
              H_START:
              begin
                // A current read opens directly with the read control byte.
                state_r <= (kind_r == SEE_CMD_CUR) ? H_CTRLR : H_CTRLW;
                txb_r   <= {SEE_TYPE_CODE, addr_r[10:8],
                            kind_r == SEE_CMD_CUR};
              end
              H_CTRLW:
              begin
                if (!ack_r || kind_r == SEE_CMD_POLL)
                begin
                  nack_r  <= !ack_r;
                  state_r <= H_STOP;
                end
                else
                begin
                  state_r <= H_ADDR;
                  txb_r   <= addr_r[7:0];
                end
              end
              H_ADDR:
              begin
                nack_r  <= !ack_r;
                state_r <= !ack_r ? H_STOP :
                           (kind_r == SEE_CMD_RAND) ? H_RESTART : H_DATA;
                txb_r   <= data_r;
              end
              H_DATA:
              begin
                nack_r  <= !ack_r;
                state_r <= H_STOP;
              end
              H_RESTART:
              begin
                state_r <= H_CTRLR;
                txb_r   <= {SEE_TYPE_CODE, addr_r[10:8], 1'b1};
              end
              H_CTRLR:
              begin
                nack_r  <= !ack_r;
                state_r <= ack_r ? H_READ : H_STOP;
              end
              H_READ:
              begin
                RD_DATA_O  <= rxb_r;
                RD_VALID_O <= 1'b1;
                left_r     <= left_r - 8'h01;
                state_r    <= (left_r == 8'h01) ? H_STOP : H_READ;
              end
              H_STOP:
              begin
                state_r <= H_IDLE;
                DONE_O  <= 1'b1;
                NACK_O  <= nack_r;
              end
              default:
                state_r <= H_IDLE;
            endcase
          end
        end
      end
    end
  end

  assign CMD_READY_O      = (state_r == H_IDLE);
  assign LINK.scl         = scl_r;
  assign LINK.host_sda_o  = 1'b0;
  assign LINK.host_sda_oe = oe_r;

endmodule : seeprm_host

// ---- hw/seeprm_pkg.sv ----
// Shared constants and types of the two-wire serial memory link.
// Assumes both ends are compiled against this package.
package seeprm_pkg;

  localparam int          SEE_ADDR_W     = 11;
  localparam int          SEE_DEPTH      = 2048;
  localparam logic [3:0]  SEE_TYPE_CODE  = 4'ha;
  localparam logic [10:0] SEE_PTR_RST    = 11'h000;
  localparam logic [3:0]  SEE_PIN_RST    = 4'h3;

  // Self-timed write cycle, counted on the link clock.
  localparam longint      SEE_WR_CYCLE_NS   = 10000000;
  localparam longint      SEE_LINK_PERIOD_PS = 6000;
  localparam int          SEE_WR_CYCLES  =
    int'((SEE_WR_CYCLE_NS * 64'd1000) / SEE_LINK_PERIOD_PS);

  // Serial clock made by the master: four quarters per bit.
  localparam longint      SEE_CLK_HZ     = 100000000;
  localparam longint      SEE_SCL_HZ     = 100000;
  localparam int          SEE_SCL_QTR    =
    int'(SEE_CLK_HZ / (64'd4 * SEE_SCL_HZ));

  typedef enum logic [1:0] {
    SEE_CMD_WRITE = 2'h0,
    SEE_CMD_CUR   = 2'h1,
    SEE_CMD_RAND  = 2'h2,
    SEE_CMD_POLL  = 2'h3
  } seeprm_cmd_t;

  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_CTRL  = 3'h1,
    D_ADDR  = 3'h3,
    D_WDATA = 3'h2,
    D_RDATA = 3'h6
  } seeprm_dst_t;

  typedef enum logic [3:0] {
    H_IDLE    = 4'h0,
    H_START   = 4'h1,
    H_CTRLW   = 4'h3,
    H_ADDR    = 4'h2,
    H_DATA    = 4'h6,
    H_STOP    = 4'h7,
    H_RESTART = 4'h5,
    H_CTRLR   = 4'h4,
    H_READ    = 4'hc
  } seeprm_hst_t;

endpackage : seeprm_pkg

// ---- hw/seeprm_if.sv ----
// Two-wire link between the master end and the memory end.
// The data line is open drain; its level is resolved here from enables.
`timescale 1ns/1ps
interface seeprm_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // A pulled-up wire: low when either end pulls it low.
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface : seeprm_if

// ---- hw/seeprm_dev.sv ----
// Memory end of the two-wire link: addressing, reads, write polling, lock.
// Runs on a free link clock that oversamples the serial clock and data.
`timescale 1ns/1ps
module seeprm_dev #(
  parameter int WR_CYCLES = seeprm_pkg::SEE_WR_CYCLES
) (
  input  wire logic       LINK_CLK_I,
  input  wire logic       RST_I,
  seeprm_if.dev           LINK,
  input  wire logic       WRITE_LOCK_I,
  input  wire logic       SUPPLY_LOW_I,
  input  wire logic [2:0] UNUSED_SELECT_PINS_I,
  output logic            BUSY_O
);
  import seeprm_pkg::*;

  logic [3:0]            s1_r;
  logic [3:0]            s2_r;
  logic [3:0]            s3_r;
  logic [3:0]            f_r;
  logic [3:0]            fd_r;
  logic                  scl;
  logic                  sda;
  logic                  lock;
  logic                  low;
  logic                  start_ev;
  logic                  stop_ev;
  logic                  rise;
  logic                  fall;
  seeprm_dst_t           state_r;
  seeprm_dst_t           nxt_r;
  logic [3:0]            bit_cnt_r;
  logic [7:0]            shift_r;
  logic                  oe_r;
  logic                  mack_r;
  logic [2:0]            blk_r;
  logic [SEE_ADDR_W-1:0] ptr_r;
  logic                  pend_v_r;
  logic [SEE_ADDR_W-1:0] pend_addr_r;
  logic [7:0]            pend_data_r;
  logic [23:0]           timer_r;
  logic                  busy_r;
  logic                  launch;
  logic [7:0]            mem [SEE_DEPTH];
  logic [7:0]            mem_q;

  // The select pins have no path into the logic at all.
  logic                  unused_sel;
  assign unused_sel = ^UNUSED_SELECT_PINS_I;

  // Bits: 0 clock, 1 data, 2 lock, 3 low supply. A change is taken only
  // once the second and third stages agree, which also rejects spikes.
  always_ff @(posedge LINK_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s1_r <= SEE_PIN_RST;
      s2_r <= SEE_PIN_RST;
      s3_r <= SEE_PIN_RST;
      f_r  <= SEE_PIN_RST;
      fd_r <= SEE_PIN_RST;
    end
    else
    begin
      s1_r <= {SUPPLY_LOW_I, WRITE_LOCK_I, LINK.sda, LINK.scl};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r  <= (s2_r & s3_r) | ((s2_r ^ s3_r) & f_r);
      fd_r <= f_r;
    end
  end

  assign scl      = f_r[0];
  assign sda      = f_r[1];
  assign lock     = f_r[2];
  assign low      = f_r[3];
  assign start_ev = scl && fd_r[0] && fd_r[1] && !sda;
  assign stop_ev  = scl && fd_r[0] && !fd_r[1] && sda;
  assign rise     = scl && !fd_r[0];
  assign fall     = !scl && fd_r[0];
  assign mem_q    = mem[ptr_r];

  always_ff @(posedge LINK_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_r     <= D_IDLE;
      nxt_r       <= D_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      oe_r        <= 1'b0;
      mack_r      <= 1'b0;
      blk_r       <= 3'h0;
      ptr_r       <= SEE_PTR_RST;
      pend_v_r    <= 1'b0;
      pend_addr_r <= SEE_PTR_RST;
      pend_data_r <= 8'h00;
    end
    else if (start_ev)
    begin
      // A repeated start drops any unsent data, so no write is launched.
      state_r   <= D_CTRL;
      // The clock fall that closes the start carries no bit, so the count
      // starts one below zero and that fall brings it to zero.
      bit_cnt_r <= 4'hf;
      oe_r      <= 1'b0;
      pend_v_r  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r   <= D_IDLE;
      bit_cnt_r <= 4'h0;
      oe_r      <= 1'b0;
      pend_v_r  <= 1'b0;
    end
    else if (state_r != D_IDLE)
    begin
      if (rise)
      begin
        if (state_r != D_RDATA && bit_cnt_r < 4'h8)
          shift_r <= {shift_r[6:0], sda};
        if (state_r == D_RDATA && bit_cnt_r == 4'h8)
          mack_r <= !sda;
      end
      if (fall)
      begin
        if (bit_cnt_r == 4'h8)
        begin
          bit_cnt_r <= 4'h0;
          if ((state_r == D_RDATA && mack_r) ||
              (state_r != D_RDATA && nxt_r == D_RDATA))
          begin
            state_r <= D_RDATA;
            shift_r <= mem_q;
            oe_r    <= !mem_q[7];
            ptr_r   <= ptr_r + 11'h001;
          end
          else if (state_r == D_RDATA)
          begin
            state_r <= D_IDLE;
            oe_r    <= 1'b0;
          end
          else
          begin
            state_r <= nxt_r;
            oe_r    <= 1'b0;
          end
        end
        else if (state_r == D_RDATA)
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == 4'h7)
            oe_r <= 1'b0;
          else
          begin
            oe_r    <= !shift_r[6];
            shift_r <= {shift_r[6:0], 1'b0};
          end
        end
        else if (bit_cnt_r == 4'h7)
        begin
          bit_cnt_r <= 4'h8;
          oe_r      <= 1'b0;
          nxt_r     <= D_IDLE;
          if (!busy_r)
          begin
            unique case (state_r)
              D_CTRL:
              begin
                if (shift_r[7:4] == SEE_TYPE_CODE)
                begin
                  oe_r  <= 1'b1;
                  blk_r <= shift_r[3:1];
                  if (shift_r[0])
                  begin
                    nxt_r        <= D_RDATA;
                    ptr_r[10:8]  <= shift_r[3:1];
                  end
                  else
                    nxt_r <= D_ADDR;
                end
              end
              D_ADDR:
              begin
                oe_r  <= 1'b1;
                ptr_r <= {blk_r, shift_r};
                nxt_r <= D_WDATA;
              end
              D_WDATA:
              begin
                oe_r        <= 1'b1;
                pend_v_r    <= 1'b1;
                pend_addr_r <= ptr_r;
                pend_data_r <= shift_r;
                ptr_r       <= ptr_r + 11'h001;
                nxt_r       <= D_WDATA;
              end
              default:
                nxt_r <= D_IDLE;
            endcase
          end
        end
        else
          bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // The cycle runs even when locked so that polling behaves the same;
  // only a low supply keeps the write logic from starting at all.
  assign launch = stop_ev && pend_v_r && !low;

  always_ff @(posedge LINK_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      timer_r <= 24'h000000;
      busy_r  <= 1'b0;
    end
    else if (launch)
    begin
      timer_r <= 24'(WR_CYCLES);
      busy_r  <= 1'b1;
    end
    else if (timer_r > 24'h000001)
      timer_r <= timer_r - 24'h000001;
    else
    begin
      timer_r <= 24'h000000;
      busy_r  <= 1'b0;
    end
  end

  // The array itself holds no reset.
  always_ff @(posedge LINK_CLK_I)
  begin
    if (launch && !lock)
      mem[pend_addr_r] <= pend_data_r;
  end

  assign LINK.dev_sda_o  = 1'b0;
  assign LINK.dev_sda_oe = oe_r;
  assign BUSY_O          = busy_r;

endmodule : seeprm_dev

// ---- verification/seeprm_assertions.sv ----
// Concurrent checks on the two-wire link between master and memory ends.
// Assumes plain link signals, the link clock and the shared reset as inputs.
`timescale 1ns/1ps
module seeprm_assertions #(
  parameter int WR_CYCLES = 1000
) (
  input wire logic LINK_CLK_I,
  input wire logic RST_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic BUSY_O,
  input wire logic SUPPLY_LOW_I
);
  default clocking cb @(posedge LINK_CLK_I); endclocking
  default disable iff (RST_I);

  int busy_cnt_r;
  int scl_hi_r;

  always_ff @(posedge LINK_CLK_I or posedge RST_I)
  begin
    if (RST_I) busy_cnt_r <= 0;
    else busy_cnt_r <= BUSY_O ? busy_cnt_r + 1 : 0;
  end

  // A long high clock means no transfer is running.
  always_ff @(posedge LINK_CLK_I or posedge RST_I)
  begin
    if (RST_I) scl_hi_r <= 0;
    else if (!scl)
      scl_hi_r <= 0;
    else if (scl_hi_r < 1000)
      scl_hi_r <= scl_hi_r + 1;
  end

  a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("memory end drove the data line high");
  a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
    else $error("master end drove the data line high");
  a_busy_no_ack: assert property (BUSY_O |-> !dev_sda_oe)
    else $error("memory end pulled data low while busy");
  a_busy_on_stop: assert property ($rose(BUSY_O) |-> scl && sda)
    else $error("write cycle started outside a stop");
  a_supply_blocks: assert property ($rose(BUSY_O) |-> !SUPPLY_LOW_I)
    else $error("write cycle started with low supply");
  a_busy_bounded: assert property (BUSY_O |-> busy_cnt_r < WR_CYCLES + 4)
    else $error("write cycle lasted too long");
  a_busy_full: assert property ($fell(BUSY_O) |-> busy_cnt_r >= WR_CYCLES - 4)
    else $error("write cycle ended too early");
  a_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("memory end pulled data while clock high");
  a_release_scl_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("memory end released data while clock high");
  a_idle_released: assert property (scl_hi_r > 60 |-> !dev_sda_oe)
    else $error("memory end holds data line on an idle bus");

  c_busy: cover property ($rose(BUSY_O));
  c_busy_end: cover property ($fell(BUSY_O));
  c_dev_drive: cover property ($rose(dev_sda_oe));
endmodule : seeprm_assertions

// ---- verification/tb.sv ----
// Self-checking bench: master end and memory end joined by the link.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/1ps
module tb;
  import seeprm_pkg::*;
  localparam int WR_CYC = 1000;

  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  seeprm_cmd_t cmd_kind = SEE_CMD_WRITE;
  logic [10:0] cmd_addr = 11'h000;
  logic [7:0]  cmd_data = 8'h00;
  logic [7:0]  cmd_len = 8'h01;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        done;
  logic        nack;
  logic        wlock = 1'b0;
  logic        supply_low = 1'b0;
  logic [2:0]  unused_sel = 3'h0;
  logic        busy;
  logic        nack_seen;
  logic [7:0]  rd_q[$];
  logic [7:0]  exp_mem [0:2047];
  logic [10:0] exp_ptr = 11'h000;
  int          err_count = 0;
  int          n_tests = 0;

  always #5 clk = ~clk;
  initial #1.3 forever #3 link_clk = ~link_clk;

  seeprm_if link_if ();

  seeprm_host #(.SCL_QTR(8)) u_seeprm_host (
    .CLOCK_I(clk), .RST_I(rst), .LINK(link_if.host),
    .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
    .CMD_KIND_I(cmd_kind), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
    .CMD_LEN_I(cmd_len), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .DONE_O(done), .NACK_O(nack));

  seeprm_dev #(.WR_CYCLES(WR_CYC)) u_seeprm_dev (
    .LINK_CLK_I(link_clk), .RST_I(rst), .LINK(link_if.dev),
    .WRITE_LOCK_I(wlock), .SUPPLY_LOW_I(supply_low),
    .UNUSED_SELECT_PINS_I(unused_sel), .BUSY_O(busy));

  seeprm_assertions #(.WR_CYCLES(WR_CYC)) u_seeprm_assertions (
    .LINK_CLK_I(link_clk), .RST_I(rst), .scl(link_if.scl),
    .sda(link_if.sda), .host_sda_o(link_if.host_sda_o),
    .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe(link_if.dev_sda_oe), .BUSY_O(busy),
    .SUPPLY_LOW_I(supply_low));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk1

  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    // An unknown expectation is a location never written: a bench fault.
    if ($isunknown(e) || g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk8

  // The select pins change on every command; the memory end must not care.
  task automatic run_cmd(input seeprm_cmd_t k, input logic [10:0] a,
                         input logic [7:0] d, input logic [7:0] n);
    int c;
    rd_q.delete();
    @(posedge clk);
    cmd_valid  <= 1'b1;
    cmd_kind   <= k;
    cmd_addr   <= a;
    cmd_data   <= d;
    cmd_len    <= n;
    unused_sel <= unused_sel + 3'h1;
    do
      @(posedge clk);
    while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk1("ready while running", 1'b0, cmd_ready);
    c = 0;
    do
    begin
      @(negedge clk);
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      c++;
    end
    while (done !== 1'b1 && c < 20000);
    chk1("command done", 1'b1, done);
    chk1("ready after done", 1'b1, cmd_ready);
    nack_seen = nack;
  endtask : run_cmd

  task automatic t_write(input logic [10:0] a, input logic [7:0] d,
                         input logic stored, input logic busy_exp);
    int k;
    run_cmd(SEE_CMD_WRITE, a, d, 8'h01);
    chk1("write nack", 1'b0, nack_seen);
    if (stored) exp_mem[a] = d;
    exp_ptr = a + 11'h001;
    k = 0;
    if (busy_exp)
    begin
      while (busy !== 1'b1 && k < 50)
      begin
        @(negedge clk);
        k++;
      end
      chk1("busy after stop", 1'b1, busy);
      run_cmd(SEE_CMD_POLL, a, 8'h00, 8'h01);
      chk1("poll while busy", 1'b1, nack_seen);
      while (nack_seen !== 1'b0 && k < 60)
      begin
        run_cmd(SEE_CMD_POLL, a, 8'h00, 8'h01);
        k += 10;
      end
      chk1("poll after cycle", 1'b0, nack_seen);
    end
    else
    begin
      // Long enough that a launched cycle would surely show.
      repeat (50) @(negedge clk);
      chk1("busy on low supply", 1'b0, busy);
      run_cmd(SEE_CMD_POLL, a, 8'h00, 8'h01);
      chk1("poll on low supply", 1'b0, nack_seen);
    end
  endtask : t_write

  task automatic t_read(input seeprm_cmd_t k, input logic [10:0] a,
                        input logic [7:0] n);
    logic [10:0] p;
    run_cmd(k, a, 8'h00, n);
    chk1("read nack", 1'b0, nack_seen);
    chk8("byte count", n, 8'(rd_q.size()));
    p = (k == SEE_CMD_CUR) ? exp_ptr : a;
    foreach (rd_q[i])
    begin
      chk8("read byte", exp_mem[p], rd_q[i]);
      p = p + 11'h001;
    end
    exp_ptr = p;
  endtask : t_read

  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_write(11'h7ff, 8'h5a, 1'b1, 1'b1);
    t_write(11'h000, 8'ha5, 1'b1, 1'b1);
    t_write(11'h123, 8'h3c, 1'b1, 1'b1);
    t_write(11'h124, 8'h96, 1'b1, 1'b1);
    t_write(11'h122, 8'hc3, 1'b1, 1'b1);
    t_read(SEE_CMD_CUR, exp_ptr, 8'h01);
    t_read(SEE_CMD_RAND, 11'h7ff, 8'h02);
    t_read(SEE_CMD_RAND, 11'h122, 8'h02);
    t_read(SEE_CMD_CUR, exp_ptr, 8'h01);
    @(posedge clk);
    wlock <= 1'b1;
    repeat (10) @(posedge clk);
    t_write(11'h123, 8'hff, 1'b0, 1'b1);
    t_read(SEE_CMD_RAND, 11'h123, 8'h01);
    @(posedge clk);
    wlock      <= 1'b0;
    supply_low <= 1'b1;
    repeat (10) @(posedge clk);
    t_write(11'h122, 8'h00, 1'b0, 1'b0);
    @(posedge clk);
    supply_low <= 1'b0;
    t_read(SEE_CMD_RAND, 11'h122, 8'h01);
    test_done();
  end
endmodule : tb
